// ===== rtl/dcd_consts.vh
// Constants for the command decoder: addresses, bit positions, codes
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH
// Mode register addresses
`define DCD_MA_FEATURE 6'h00
`define DCD_MA_FSP 6'h0D
`define DCD_MA_SE_CFG 6'h33
// Field positions
`define DCD_WRITE_SET_POINT_SELECT_BIT 6
`define DCD_OPERATING_SET_POINT_SELECT_BIT 7
`define DCD_SE_RDQS_BIT 1
`define DCD_SE_WDQS_BIT 2
`define DCD_SE_CLK_BIT 3
`define DCD_FEAT_SE_BIT 5
// Reset values
`define DCD_SE_CFG_RST 3'h0
`define DCD_FSP_RST 1'h0
// Command codes
`define DCD_C_MPC 4'h0
`define DCD_C_PRE 4'h1
`define DCD_C_REF 4'h2
`define DCD_C_SRE 4'h3
`define DCD_C_WR1 4'h4
`define DCD_C_SRX 4'h5
`define DCD_C_MWR1 4'h6
`define DCD_C_RD1 4'h7
`define DCD_C_CAS2 4'h8
`define DCD_C_MRW1 4'h9
`define DCD_C_MRW2 4'hA
`define DCD_C_MRR1 4'hB
`define DCD_C_ACT1 4'hC
`define DCD_C_ACT2 4'hD
`define DCD_C_RFU 4'hF
// Follow-up expected after a first half command
`define DCD_NEED_NONE 2'h0
`define DCD_NEED_CAS 2'h1
`define DCD_NEED_ACT2 2'h2
`define DCD_NEED_MRW2 2'h3
`endif

// ===== rtl/dcd_sync.v
// Three-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dcd_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // Asynchronous input
    input wire [W-1:0] i_d,
    // Second and third stages
    output wire [W-1:0] o_q2,
    output wire [W-1:0] o_q3
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign o_q2 = s2_r;
    assign o_q3 = s3_r;
endmodule // dcd_sync

// ===== rtl/dcd_top.v
// Two-cycle command decoder with single-ended clock and strobe configuration
`timescale 1ns/1ps
`include "dcd_consts.vh"
// Notes on behaviour
// - Undefined sequence is illegal until reset
// - Test-reserved register writes change nothing
// - Config bit 1 selects single-ended read strobe
// - Config bit 2 selects single-ended write strobe
// - Config bit 3 selects single-ended clock
// - Writes update copy chosen by write select
// - Operation uses copy chosen by operating select
// - Inactive copy ignored, freely rewritable
// - Feature register bit 5 reports single-ended support
// - Complement read strobe floats in single-ended mode
// - Self-refresh entry decode
// - Self-refresh exit decode
// - Refresh decode with bank bits
// - Precharge decode with bank bits
// - CAS-2 carries column bits 2 to 8
// - Commands take two edges, deselect one
// - All-bank flag ignores bank address
// - Burst flag picks 32 or 16 beats
module dcd_top #(
    parameter FEAT_SE_SUPPORT = 1'b1
) (
    // System clock and reset
    input wire I_CLK_SYS,
    input wire I_RST_B,
    // Command bus from controller
    input wire I_CK_T,
    input wire I_CKE,
    input wire I_CS,
    input wire [5:0] I_CA,
    // Static options
    input wire I_BL_OTF_EN,
    // Internal read strobe source
    input wire I_RDQS_EN,
    input wire I_RDQS,
    // Decoded command
    output reg O_CMD_VALID,
    output reg [3:0] O_CMD_CODE,
    output reg [2:0] O_BANK,
    output reg O_ALL_BANK,
    output reg [15:0] O_ROW,
    output reg [9:0] O_COL,
    output reg O_AP,
    output reg O_BL32,
    output reg [6:0] O_MPC_OP,
    output reg O_ILLEGAL,
    // Mode register read answer
    output reg O_MRR_VALID,
    output reg [7:0] O_MRR_DATA,
    // Active single-ended configuration
    output wire O_SE_RDQS,
    output wire O_SE_WDQS,
    output wire O_SE_CLK,
    // Read strobe pins
    output reg O_RDQS_T,
    output reg O_RDQS_T_OE_B,
    output reg O_RDQS_C,
    output reg O_RDQS_C_OE_B
);
    localparam ST_R1 = 3'b001;
    localparam ST_R2 = 3'b010;
    localparam ST_HALT = 3'b100;

    wire [8:0] q2;
    wire [8:0] q3;
    reg ck_lvl_r;
    reg [2:0] st_r;
    reg [3:0] cmd_r;
    reg [5:0] ca1_r;
    reg [1:0] need_r;
    reg cas_opt_r;
    reg [5:0] ma_r;
    reg op7_r;
    reg [3:0] row_hi_r;
    reg [2:0] bank_r;
    reg c9_r;
    reg ap_r;
    reg bl_r;
    reg [3:0] pend_r;
    reg write_set_point_select_r;
    reg operating_set_point_select_r;
    reg [2:0] se_sp0_r;
    reg [2:0] se_sp1_r;
    wire ck_rise;
    wire [5:0] ca;
    wire [3:0] cls;
    wire [2:0] se_act;
    wire [7:0] mrw_op;

    function [3:0] classify;
        input [5:0] c;
        begin
            if (c[0])
                classify = c[1] ? `DCD_C_ACT2 : `DCD_C_ACT1;
            else begin
                case ({c[1], c[2], c[3], c[4]})
                    4'h0: classify = `DCD_C_MPC;
                    4'h1: classify = `DCD_C_PRE;
                    4'h2: classify = `DCD_C_REF;
                    4'h3: classify = `DCD_C_SRE;
                    4'h4: classify = `DCD_C_WR1;
                    4'h5: classify = `DCD_C_SRX;
                    4'h6: classify = c[5] ? `DCD_C_RFU : `DCD_C_MWR1;
                    4'h8: classify = `DCD_C_RD1;
                    4'h9: classify = `DCD_C_CAS2;
                    4'hC: classify = `DCD_C_MRW1;
                    4'hD: classify = `DCD_C_MRW2;
                    4'hE: classify = `DCD_C_MRR1;
                    default: classify = `DCD_C_RFU;
                endcase
            end
        end
    endfunction

    // Clock, enable, select and bus share one pipeline so they stay aligned
    dcd_sync #(.W(9)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rst_b(I_RST_B),
        .i_d({I_CA, I_CKE, I_CS, I_CK_T}),
        .o_q2(q2),
        .o_q3(q3)
    );

    assign ck_rise = (q2[0] == q3[0]) && q3[0] && !ck_lvl_r;
    assign ca = q3[8:3];
    assign cls = classify(ca);
    assign mrw_op = {op7_r, ca1_r[5], ca};
    assign se_act = operating_set_point_select_r ? se_sp1_r : se_sp0_r;
    assign O_SE_RDQS = se_act[`DCD_SE_RDQS_BIT - 1];
    assign O_SE_WDQS = se_act[`DCD_SE_WDQS_BIT - 1];
    assign O_SE_CLK = se_act[`DCD_SE_CLK_BIT - 1];

    always @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B)
            ck_lvl_r <= 1'b0;
        else if (q2[0] == q3[0])
            ck_lvl_r <= q3[0];
    end

    // Command sequencer
    always @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_r <= ST_R1;
            cmd_r <= `DCD_C_RFU;
            ca1_r <= 6'h00;
            need_r <= `DCD_NEED_NONE;
            cas_opt_r <= 1'b0;
            ma_r <= 6'h00;
            op7_r <= 1'b0;
            row_hi_r <= 4'h0;
            bank_r <= 3'h0;
            c9_r <= 1'b0;
            ap_r <= 1'b0;
            bl_r <= 1'b0;
            pend_r <= `DCD_C_RFU;
            write_set_point_select_r <= `DCD_FSP_RST;
            operating_set_point_select_r <= `DCD_FSP_RST;
            se_sp0_r <= `DCD_SE_CFG_RST;
            se_sp1_r <= `DCD_SE_CFG_RST;
            O_CMD_VALID <= 1'b0;
            O_CMD_CODE <= `DCD_C_RFU;
            O_BANK <= 3'h0;
            O_ALL_BANK <= 1'b0;
            O_ROW <= 16'h0000;
            O_COL <= 10'h000;
            O_AP <= 1'b0;
            O_BL32 <= 1'b0;
            O_MPC_OP <= 7'h00;
            O_ILLEGAL <= 1'b0;
            O_MRR_VALID <= 1'b0;
            O_MRR_DATA <= 8'h00;
        end else begin
            O_CMD_VALID <= 1'b0;
            O_MRR_VALID <= 1'b0;
            case (st_r)
                ST_R1: begin
                    if (ck_rise) begin
                        if (!q3[1]) begin
                            // Deselect: one edge, breaks any pending pair
                            if (need_r != `DCD_NEED_NONE) begin
                                O_ILLEGAL <= 1'b1;
                                st_r <= ST_HALT;
                            end
                            cas_opt_r <= 1'b0;
                        end else if (!q3[2] || cls == `DCD_C_RFU ||
                                     (need_r == `DCD_NEED_CAS && cls != `DCD_C_CAS2) ||
                                     (need_r == `DCD_NEED_ACT2 && cls != `DCD_C_ACT2) ||
                                     (need_r == `DCD_NEED_MRW2 && cls != `DCD_C_MRW2) ||
                                     (need_r != `DCD_NEED_ACT2 && cls == `DCD_C_ACT2) ||
                                     (need_r != `DCD_NEED_MRW2 && cls == `DCD_C_MRW2) ||
                                     (need_r != `DCD_NEED_CAS && !cas_opt_r &&
                                      cls == `DCD_C_CAS2)) begin
                            O_ILLEGAL <= 1'b1;
                            st_r <= ST_HALT;
                        end else begin
                            cmd_r <= cls;
                            ca1_r <= ca;
                            st_r <= ST_R2;
                        end
                    end
                end
                ST_R2: begin
                    if (ck_rise) begin
                        if (q3[1]) begin
                            O_ILLEGAL <= 1'b1;
                            st_r <= ST_HALT;
                        end else begin
                            st_r <= ST_R1;
                            need_r <= `DCD_NEED_NONE;
                            cas_opt_r <= 1'b0;
                            O_ALL_BANK <= 1'b0;
                            case (cmd_r)
                                `DCD_C_MPC: begin
                                    O_MPC_OP <= {ca1_r[5], ca};
                                    cas_opt_r <= 1'b1;
                                    O_CMD_CODE <= cmd_r;
                                    O_CMD_VALID <= 1'b1;
                                end
                                `DCD_C_PRE, `DCD_C_REF: begin
                                    O_ALL_BANK <= ca1_r[5];
                                    O_BANK <= ca1_r[5] ? 3'h0 : ca[2:0];
                                    O_CMD_CODE <= cmd_r;
                                    O_CMD_VALID <= 1'b1;
                                end
                                `DCD_C_SRE, `DCD_C_SRX: begin
                                    O_CMD_CODE <= cmd_r;
                                    O_CMD_VALID <= 1'b1;
                                end
                                `DCD_C_WR1, `DCD_C_MWR1, `DCD_C_RD1: begin
                                    bank_r <= ca[2:0];
                                    c9_r <= ca[4];
                                    ap_r <= ca[5];
                                    bl_r <= (cmd_r != `DCD_C_MWR1) && ca1_r[5];
                                    pend_r <= cmd_r;
                                    need_r <= `DCD_NEED_CAS;
                                end
                                `DCD_C_MRR1: begin
                                    ma_r <= ca;
                                    pend_r <= cmd_r;
                                    need_r <= `DCD_NEED_CAS;
                                end
                                `DCD_C_MRW1: begin
                                    ma_r <= ca;
                                    op7_r <= ca1_r[5];
                                    need_r <= `DCD_NEED_MRW2;
                                end
                                `DCD_C_MRW2: begin
                                    // Other addresses, test ones included, store nothing
                                    if (ma_r == `DCD_MA_FSP) begin
                                        write_set_point_select_r <= mrw_op[`DCD_WRITE_SET_POINT_SELECT_BIT];
                                        operating_set_point_select_r <= mrw_op[`DCD_OPERATING_SET_POINT_SELECT_BIT];
                                    end else if (ma_r == `DCD_MA_SE_CFG) begin
                                        if (write_set_point_select_r)
                                            se_sp1_r <= mrw_op[`DCD_SE_CLK_BIT:1];
                                        else
                                            se_sp0_r <= mrw_op[`DCD_SE_CLK_BIT:1];
                                    end
                                    O_CMD_CODE <= cmd_r;
                                    O_CMD_VALID <= 1'b1;
                                end
                                `DCD_C_ACT1: begin
                                    row_hi_r <= ca1_r[5:2];
                                    bank_r <= ca[2:0];
                                    c9_r <= ca[4];
                                    ap_r <= ca[5];
                                    need_r <= `DCD_NEED_ACT2;
                                end
                                `DCD_C_ACT2: begin
                                    O_ROW <= {row_hi_r, ap_r, c9_r, ca1_r[5:2], ca};
                                    O_BANK <= bank_r;
                                    O_CMD_CODE <= cmd_r;
                                    O_CMD_VALID <= 1'b1;
                                end
                                `DCD_C_CAS2: begin
                                    O_COL <= {c9_r, ca1_r[5], ca, 2'b00};
                                    O_CMD_CODE <= pend_r;
                                    if (pend_r == `DCD_C_MRR1) begin
                                        O_MRR_VALID <= 1'b1;
                                        if (ma_r == `DCD_MA_FEATURE)
                                            O_MRR_DATA <= {2'b00, FEAT_SE_SUPPORT, 5'h00};
                                        else if (ma_r == `DCD_MA_FSP)
                                            O_MRR_DATA <= {operating_set_point_select_r, write_set_point_select_r, 6'h00};
                                        else
                                            O_MRR_DATA <= 8'h00;
                                    end else if (pend_r != `DCD_C_RFU) begin
                                        O_BANK <= bank_r;
                                        O_AP <= ap_r;
                                        O_BL32 <= I_BL_OTF_EN && bl_r;
                                        O_CMD_VALID <= 1'b1;
                                    end
                                    pend_r <= `DCD_C_RFU;
                                end
                                default: st_r <= ST_HALT;
                            endcase
                        end
                    end
                end
                ST_HALT: st_r <= ST_HALT;
                default: st_r <= ST_HALT;
            endcase
        end
    end

    // Read strobe pins; complement floats in single-ended mode
    always @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDQS_T <= 1'b0;
            O_RDQS_T_OE_B <= 1'b1;
            O_RDQS_C <= 1'b1;
            O_RDQS_C_OE_B <= 1'b1;
        end else begin
            O_RDQS_T <= I_RDQS;
            O_RDQS_T_OE_B <= !I_RDQS_EN;
            O_RDQS_C <= !I_RDQS;
            O_RDQS_C_OE_B <= !(I_RDQS_EN && !O_SE_RDQS);
        end
    end
endmodule // dcd_top

// ===== verif/dcd_ctrl_model.sv
// Memory controller model driving the command bus
`timescale 1ns/1ps
module dcd_ctrl_model (
    // Clock
    input wire logic i_clk,
    // Command bus
    output logic o_ck_t,
    output logic o_cke,
    output logic o_cs,
    output logic [5:0] o_ca
);
    logic cke_drop = 1'b0;
    // Complement clock and write strobe are not pins here; treated as held low
    initial begin
        o_ck_t = 1'b0;
        o_cke = 1'b1;
        o_cs = 1'b0;
        o_ca = 6'h00;
    end
    // One half: bus set, clock low 4 cycles, then high 4 cycles
    task automatic half(input logic cs, input logic [5:0] ca);
        @(posedge i_clk);
        #1;
        o_cs = cs;
        o_ca = ca;
        o_cke = !cke_drop;
        repeat (4) @(posedge i_clk);
        #1 o_ck_t = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_ck_t = 1'b0;
    endtask
    // Full command; clock stands still after it, bus no longer valid
    task automatic cmd(input logic [5:0] a, input logic [5:0] b);
        half(1'b1, a);
        half(1'b0, b);
        o_cs = 1'b0;
        o_ca = ~b;
        o_cke = 1'b1;
    endtask
endmodule // dcd_ctrl_model

// ===== verif/dcd_top_chk.sv
// Port assertions for the command decoder
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_top_chk (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    // Inputs
    input wire logic I_CK_T,
    input wire logic I_RDQS_EN,
    // Outputs
    input wire logic O_CMD_VALID,
    input wire logic [3:0] O_CMD_CODE,
    input wire logic [2:0] O_BANK,
    input wire logic O_ALL_BANK,
    input wire logic O_BL32,
    input wire logic O_ILLEGAL,
    input wire logic O_MRR_VALID,
    input wire logic O_SE_RDQS,
    input wire logic O_SE_WDQS,
    input wire logic O_SE_CLK,
    input wire logic O_RDQS_T_OE_B,
    input wire logic O_RDQS_C_OE_B
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_B);
    a_se_rdqs_float: assert property ((O_SE_RDQS && I_RDQS_EN)[*3] |-> O_RDQS_C_OE_B && !O_RDQS_T_OE_B)
        else $error("complement read strobe not floating");
    a_diff_rdqs_drive: assert property ((!O_SE_RDQS && I_RDQS_EN)[*3] |-> !O_RDQS_C_OE_B && !O_RDQS_T_OE_B)
        else $error("differential read strobe not driven");
    a_illegal_sticky: assert property (O_ILLEGAL |=> O_ILLEGAL)
        else $error("illegal flag cleared without reset");
    a_illegal_halts: assert property (O_ILLEGAL |=> !O_CMD_VALID && !O_MRR_VALID)
        else $error("decode after illegal sequence");
    a_valid_pulse: assert property (O_CMD_VALID |=> !O_CMD_VALID)
        else $error("command valid longer than one cycle");
    a_valid_after_ck: assert property (O_CMD_VALID |-> $past(I_CK_T, 3) || $past(I_CK_T, 4) || $past(I_CK_T, 5))
        else $error("command valid without clock edge");
    a_all_bank_zero: assert property (O_CMD_VALID && O_ALL_BANK |-> O_BANK == 3'h0)
        else $error("bank not zero for all-bank command");
    a_all_bank_codes: assert property (O_CMD_VALID && O_ALL_BANK |-> O_CMD_CODE inside {`DCD_C_PRE, `DCD_C_REF})
        else $error("all-bank flag on wrong command");
    a_mwr_bl16: assert property (O_CMD_VALID && O_CMD_CODE == `DCD_C_MWR1 |-> !O_BL32)
        else $error("masked write with long burst");
    a_se_on_cmd: assert property (!$stable({O_SE_RDQS, O_SE_WDQS, O_SE_CLK}) |-> O_CMD_VALID || $past(O_CMD_VALID) || $past(O_CMD_VALID, 2))
        else $error("single-ended config changed without command");
    c_act: cover property (O_CMD_VALID && O_CMD_CODE == `DCD_C_ACT2);
    c_illegal: cover property ($rose(O_ILLEGAL));
    c_mrr: cover property (O_MRR_VALID);
    c_se_rdqs: cover property (O_SE_RDQS && I_RDQS_EN && O_RDQS_C_OE_B);
endmodule // dcd_top_chk
bind dcd_top dcd_top_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_CK_T(I_CK_T),
    .I_RDQS_EN(I_RDQS_EN), .O_CMD_VALID(O_CMD_VALID), .O_CMD_CODE(O_CMD_CODE), .O_BANK(O_BANK),
    .O_ALL_BANK(O_ALL_BANK), .O_BL32(O_BL32), .O_ILLEGAL(O_ILLEGAL), .O_MRR_VALID(O_MRR_VALID),
    .O_SE_RDQS(O_SE_RDQS), .O_SE_WDQS(O_SE_WDQS), .O_SE_CLK(O_SE_CLK),
    .O_RDQS_T_OE_B(O_RDQS_T_OE_B), .O_RDQS_C_OE_B(O_RDQS_C_OE_B));

// ===== verif/dcd_top_bench.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_top_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bl_otf = 1'b1;
    logic rdqs_en = 1'b0;
    logic rdqs = 1'b0;
    wire ck_t, cke, cs, cmd_valid, all_bank, ap, bl32, illegal, mrr_valid;
    wire se_rdqs, se_wdqs, se_clk, rdqs_t, rdqs_t_oe_b, rdqs_c, rdqs_c_oe_b;
    wire [5:0] ca;
    wire [3:0] code;
    wire [2:0] bank;
    wire [15:0] row;
    wire [9:0] col;
    wire [6:0] mpc_op;
    wire [7:0] mrr_data;
    wire [2:0] se = {se_clk, se_wdqs, se_rdqs};
    int fail_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    always @(posedge clk) #1 rdqs = ~rdqs;
    dcd_ctrl_model ctrl (.i_clk(clk), .o_ck_t(ck_t), .o_cke(cke), .o_cs(cs), .o_ca(ca));
    dcd_top uut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CK_T(ck_t), .I_CKE(cke), .I_CS(cs),
        .I_CA(ca), .I_BL_OTF_EN(bl_otf), .I_RDQS_EN(rdqs_en), .I_RDQS(rdqs),
        .O_CMD_VALID(cmd_valid), .O_CMD_CODE(code), .O_BANK(bank), .O_ALL_BANK(all_bank),
        .O_ROW(row), .O_COL(col), .O_AP(ap), .O_BL32(bl32), .O_MPC_OP(mpc_op),
        .O_ILLEGAL(illegal), .O_MRR_VALID(mrr_valid), .O_MRR_DATA(mrr_data),
        .O_SE_RDQS(se_rdqs), .O_SE_WDQS(se_wdqs), .O_SE_CLK(se_clk), .O_RDQS_T(rdqs_t),
        .O_RDQS_T_OE_B(rdqs_t_oe_b), .O_RDQS_C(rdqs_c), .O_RDQS_C_OE_B(rdqs_c_oe_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk);
        #1 rst_b = 1'b0;
        settle(10);
        rst_b = 1'b1;
        settle(6);
    endtask
    // Bounded wait for the answer pulse
    task automatic wait_pulse(input bit mrr);
        for (int i = 0; i < 60; i++) begin
            settle(1);
            if ((mrr ? mrr_valid : cmd_valid) === 1'b1) return;
        end
        chk(32'h0, 32'h1);
    endtask
    task automatic run(input logic [5:0] a1, b1, a2, b2, input bit two, mrr);
        fork
            begin
                ctrl.cmd(a1, b1);
                if (two) ctrl.cmd(a2, b2);
            end
            wait_pulse(mrr);
        join
    endtask
    task automatic single(input logic [5:0] a, b, input logic [3:0] exp);
        run(a, b, 6'h00, 6'h00, 1'b0, 1'b0);
        chk(code, exp);
    endtask
    task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
        run({op[7], 5'h06}, ma, {op[6], 5'h16}, op[5:0], 1'b1, 1'b0);
        chk(code, `DCD_C_MRW2);
    endtask
    task automatic mrr(input logic [5:0] ma, input logic [7:0] exp);
        run(6'h0E, ma, 6'h12, 6'h00, 1'b1, 1'b1);
        chk(mrr_data, exp);
    endtask
    task automatic t_reset();
        chk({illegal, rdqs_c_oe_b, se}, 5'h08);
        mrr(6'h00, 8'h20);
    endtask
    task automatic t_decode();
        run(6'h29, 6'h15, 6'h1F, 6'h03, 1'b1, 1'b0);
        chk({code, bank, row}, {`DCD_C_ACT2, 3'h5, 16'hA5C3});
        single(6'h30, 6'h03, `DCD_C_PRE);
        chk({all_bank, bank}, 4'h8);
        single(6'h08, 6'h06, `DCD_C_REF);
        chk({all_bank, bank}, 4'h6);
        single(6'h18, 6'h2A, `DCD_C_SRE);
        single(6'h14, 6'h15, `DCD_C_SRX);
        single(6'h20, 6'h0D, `DCD_C_MPC);
        chk(mpc_op, 7'h4D);
        run(6'h24, 6'h32, 6'h12, 6'h2D, 1'b1, 1'b0);
        chk({code, bank, col, ap, bl32}, {`DCD_C_WR1, 3'h2, 10'h2B4, 2'b11});
        run(6'h0C, 6'h11, 6'h12, 6'h00, 1'b1, 1'b0);
        chk({code, bank, col, bl32}, {`DCD_C_MWR1, 3'h1, 10'h200, 1'b0});
        run(6'h22, 6'h07, 6'h32, 6'h00, 1'b1, 1'b0);
        chk({code, bank, col, ap, bl32}, {`DCD_C_RD1, 3'h7, 10'h100, 2'b01});
    endtask
    task automatic t_se_cfg();
        rdqs_en = 1'b1;
        settle(4);
        chk({rdqs_c_oe_b, rdqs_t_oe_b}, 2'b00);
        mrw(6'h33, 8'h0E);
        chk(se, 3'h7);
        settle(4);
        chk({rdqs_c_oe_b, rdqs_t_oe_b}, 2'b10);
        // Strobe pins lag the toggling source by one edge
        @(negedge clk);
        chk({rdqs_t, rdqs_c}, {~rdqs, rdqs});
        mrw(6'h0D, 8'h40);
        mrw(6'h33, 8'h02);
        chk(se, 3'h7);
        mrw(6'h0D, 8'h80);
        chk(se, 3'h1);
        mrr(6'h0D, 8'h80);
        mrr(6'h33, 8'h00);
        mrw(6'h30, 8'hFF);
        chk({illegal, se}, 4'h1);
        mrw(6'h0D, 8'h00);
        mrw(6'h33, 8'h00);
        settle(4);
        chk({se, rdqs_c_oe_b}, 4'h0);
    endtask
    // Unknown code, lone second half, clock enable low
    task automatic t_fault();
        for (int k = 0; k < 3; k++) begin
            do_reset();
            ctrl.cke_drop = (k == 2);
            ctrl.cmd(k == 0 ? 6'h1C : (k == 1 ? 6'h12 : 6'h18), 6'h00);
            ctrl.cke_drop = 1'b0;
            settle(8);
            chk(illegal, 1'b1);
            ctrl.cmd(6'h18, 6'h00);
            settle(8);
            chk(illegal, 1'b1);
        end
        // Lone deselect is legal, deselect inside an activate pair is not
        do_reset();
        ctrl.half(1'b0, 6'h00);
        settle(8);
        chk(illegal, 1'b0);
        ctrl.cmd(6'h01, 6'h00);
        ctrl.half(1'b0, 6'h00);
        settle(8);
        chk(illegal, 1'b1);
        do_reset();
        chk(illegal, 1'b0);
    endtask
    initial begin
        settle(10);
        rst_b = 1'b1;
        settle(6);
        t_reset();
        t_decode();
        t_se_cfg();
        t_fault();
        final_report();
    end
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule // dcd_top_bench
